// >>> dafu_core.sv
// data address and flag unit: address modes, tag memory, test flags, bus slave
// What this block does
// - index mode: register plus index, registers unchanged
// - short mode: page plus unsigned 7-bit offset
// - long mode: base plus second word
// - flag ops touch only bit 16
// - flag bit0 clear: six-bit field is address
// - flag bit0 set: page plus six-bit offset
// - page register is word address for flags
// - flag load, store, and, or, xor
// - memory holds 640 words of 17 bits
// - accumulator load copies tag into status
// - byte tag set/clear drops address LSB
// - word tag set/clear uses word address
// - byte tag ops accept five address modes
// - word tag ops finish in one cycle
// - flag moves use word addresses
`timescale 1ns/1ps
`include "dafu_consts.svh"
module dafu_core
    import dafu_pkg::*;
#(
    parameter int RAM_WORDS = `DAFU_RAM_WORDS
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST
);
    // full state of the block
    typedef struct packed {
        dafu_state_t   st;
        dafu_cmd_t     cmd;
        logic [2:0]    reg_ptr;
        logic [15:0]   opnd;
        logic [16:0]   wdata;
        logic [16:0]   rdata;
        logic [15:0]   last_addr;
        logic          test_flag_one;
        logic          test_flag_two;
        logic          stat_tag;
        logic [31:0]   bus_rdata;
        logic          bus_ack;
        logic          busy;
        logic          second_word;
        logic [7:0][15:0] addr_reg;
    } dafu_st_t;

    // registered state and its next value
    dafu_st_t s_q;
    dafu_st_t s_d;

    logic          rst_meta_n;
    logic          rst_n;
    dafu_ram_req_t ram_req;
    logic          ram_vld;
    logic [16:0]   ram_rdata;
    logic [15:0]   eff_addr;
    logic [9:0]    eff_waddr;
    logic          mem_tag;
    logic          new_flag;
    logic          bus_hit;
    logic          is_tag_op;
    logic          stall_word2;
    logic          addr_over;
    logic          wr_ok;
    logic [16:0]   mem_word;

    // the ten-bit word address cannot serve more than 1024 words
    if (RAM_WORDS < 64 || RAM_WORDS > 1024) begin : g_bad_words
        $error("dafu_core: RAM_WORDS out of range");
    end

    // reset release through two flops; entry stays asynchronous so the
    // block goes quiet at once, while release waits for the clock
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // selected flag bit of a command
    function automatic logic flag_of(input dafu_st_t s);
        return s.cmd.flg_sel ? s.test_flag_two : s.test_flag_one;
    endfunction : flag_of

    // direct and long modes carry a second instruction word
    function automatic logic two_word(input logic [2:0] mode);
        return (mode == `DAFU_MODE_DIRECT) || (mode == `DAFU_MODE_LONG);
    endfunction : two_word

    // status word as software reads it
    function automatic logic [31:0] status_word(input dafu_st_t s);
        return 32'({s.busy, s.stat_tag, s.test_flag_two, s.test_flag_one});
    endfunction : status_word

    // byte-address operand modes, sums wrap to 16 bits
    function automatic logic [15:0] byte_addr(input dafu_st_t s);
        logic [15:0] base;
        base = s.addr_reg[s.cmd.reg_sel];
        case (s.cmd.mode)
            `DAFU_MODE_DIRECT:   byte_addr = s.opnd;
            `DAFU_MODE_INDIRECT: byte_addr = base;
            `DAFU_MODE_INDEX:    byte_addr = 16'(base + s.addr_reg[`DAFU_REG_INDEX]);
            `DAFU_MODE_SHORT:    byte_addr = 16'(s.addr_reg[`DAFU_REG_PAGE]
                                             + {9'h000, s.opnd[6:0]});
            `DAFU_MODE_LONG:     byte_addr = 16'(base + s.opnd);
            default:             byte_addr = s.opnd;
        endcase
    endfunction : byte_addr

    // flag addressing gives a word address directly
    function automatic logic [15:0] flag_addr(input dafu_st_t s);
        logic [15:0] ofs;
        ofs = {10'h000, s.cmd.flag_field[`DAFU_FLG_OFS_HI:`DAFU_FLG_OFS_LO]};
        if (s.cmd.flag_field[`DAFU_FLG_REL_BIT]) begin
            flag_addr = 16'(s.addr_reg[`DAFU_REG_PAGE] + ofs);
        end else begin
            flag_addr = ofs;
        end
    endfunction : flag_addr

    // word address per instruction family; upper bits past the word space
    // are not folded back, so an address past the word space cannot alias a low word
    always_comb begin
        is_tag_op = (s_q.cmd.op >= `DAFU_OP_SET_TAGW) && (s_q.cmd.op <= `DAFU_OP_FLG_XOR);
        if (is_tag_op) begin
            eff_addr  = flag_addr(s_q);
            eff_waddr = eff_addr[9:0];          // word address
            addr_over = |eff_addr[15:10];
        end else begin
            eff_addr  = byte_addr(s_q);         // byte modes
            eff_waddr = eff_addr[10:1];         // LSB dropped
            addr_over = |eff_addr[15:11];
        end
        // two-word byte modes spend one cycle on the second word
        stall_word2 = !is_tag_op && two_word(s_q.cmd.mode) && !s_q.second_word
                      && (s_q.cmd.op != `DAFU_OP_IDLE)
                      && (s_q.cmd.op != `DAFU_OP_REG_WR);
    end

    // words past the memory read as zero and are never written
    assign mem_word = addr_over ? 17'h00000 : ram_rdata;
    assign mem_tag  = mem_word[`DAFU_TAG_BIT];

    // flag logic on the memory tag
    always_comb begin
        case (s_q.cmd.op)
            `DAFU_OP_FLG_LOAD: new_flag = mem_tag;
            `DAFU_OP_FLG_AND:  new_flag = flag_of(s_q) & mem_tag;
            `DAFU_OP_FLG_OR:   new_flag = flag_of(s_q) | mem_tag;
            `DAFU_OP_FLG_XOR:  new_flag = flag_of(s_q) ^ mem_tag;
            default:           new_flag = flag_of(s_q);
        endcase
    end

    // memory request driven during execution
    always_comb begin
        ram_req.waddr    = eff_waddr;
        ram_req.we       = 1'b0;
        ram_req.tag_only = 1'b1;
        ram_req.wdata    = s_q.wdata;
        ram_vld          = (s_q.st == DAFU_ST_EXEC) && !stall_word2
                           && !addr_over;  // out-of-range writes dropped
        case (s_q.cmd.op)
            `DAFU_OP_STORE_ACC: begin
                ram_req.we       = 1'b1;
                ram_req.tag_only = 1'b0;
            end
            `DAFU_OP_SET_TAGB, `DAFU_OP_SET_TAGW: begin
                ram_req.we                   = 1'b1;
                ram_req.wdata[`DAFU_TAG_BIT] = 1'b1;
            end
            `DAFU_OP_CLR_TAGB, `DAFU_OP_CLR_TAGW: begin
                ram_req.we                   = 1'b1;
                ram_req.wdata[`DAFU_TAG_BIT] = 1'b0;
            end
            `DAFU_OP_FLG_STORE: begin
                ram_req.we                   = 1'b1;  // tag-only write
                ram_req.wdata[`DAFU_TAG_BIT] = flag_of(s_q);
            end
            default: ram_req.we = 1'b0;
        endcase
    end

    dafu_tag_ram #(
        .WORDS (RAM_WORDS)
    ) u_ram (
        .clk     (CLK_SYS),
        .req     (ram_req),
        .req_vld (ram_vld),
        .rdata   (ram_rdata)
    );

    assign bus_hit = AVS_READ | AVS_WRITE;

    // writes while busy or with partial byte enables are acked but dropped
    assign wr_ok = !s_q.busy && (AVS_BYTEENABLE == 4'hF);

    // next state: bus slave plus execution sequence
    always_comb begin
        s_d         = s_q;
        s_d.bus_ack = 1'b0;
        case (s_q.st)
            DAFU_ST_IDLE: s_d.busy = 1'b0;
            DAFU_ST_EXEC: begin
                s_d.last_addr = eff_addr;
                if (stall_word2) begin
                    s_d.second_word = 1'b1;         // second word consumed
                end else begin
                    s_d.second_word = 1'b0;
                    if (s_q.cmd.op == `DAFU_OP_REG_WR) begin
                        s_d.addr_reg[s_q.reg_ptr] = s_q.wdata[15:0];
                    end
                    // writes and register loads need no read-back cycle
                    if (ram_req.we || s_q.cmd.op == `DAFU_OP_IDLE
                        || s_q.cmd.op == `DAFU_OP_REG_WR) begin
                        s_d.st = DAFU_ST_DONE;      // writes end here
                    end else begin
                        s_d.st = DAFU_ST_WAIT;
                    end
                end
            end
            DAFU_ST_WAIT: begin
                // flag results land in the flag the command picks
                s_d.rdata = mem_word;
                if (s_q.cmd.op == `DAFU_OP_LOAD_ACC) begin
                    s_d.stat_tag = mem_tag;
                end else if (s_q.cmd.flg_sel) begin
                    s_d.test_flag_two = new_flag;
                end else begin
                    s_d.test_flag_one = new_flag;
                end
                s_d.st = DAFU_ST_DONE;
            end
            DAFU_ST_DONE: begin
                s_d.busy = 1'b0;
                s_d.st   = DAFU_ST_IDLE;
            end
            default: s_d.st = DAFU_ST_IDLE;
        endcase

        // register accesses answer one cycle after the request
        if (bus_hit && !s_q.bus_ack) begin
            s_d.bus_ack = 1'b1;
            s_d.bus_rdata = 32'h00000000;
            if (AVS_READ) begin
                case (AVS_ADDRESS)
                    `DAFU_BUS_CMD:     s_d.bus_rdata = 32'({s_q.cmd});
                    `DAFU_BUS_REG_SEL: s_d.bus_rdata = 32'({s_q.reg_ptr});
                    `DAFU_BUS_OPND:    s_d.bus_rdata = 32'({s_q.opnd});
                    `DAFU_BUS_WDATA:   s_d.bus_rdata = 32'({s_q.wdata});
                    `DAFU_BUS_RDATA:   s_d.bus_rdata = 32'({s_q.rdata});
                    `DAFU_BUS_STATUS:  s_d.bus_rdata = status_word(s_q);
                    `DAFU_BUS_ADDR:    s_d.bus_rdata = 32'({s_q.last_addr});
                    default:           s_d.bus_rdata = 32'h00000000;
                endcase
            end else if (wr_ok) begin
                // refused writes still answer so the master never hangs
                case (AVS_ADDRESS)
                    `DAFU_BUS_CMD:     s_d.cmd     = dafu_cmd_t'(AVS_WRITEDATA[17:0]);
                    `DAFU_BUS_REG_SEL: s_d.reg_ptr = AVS_WRITEDATA[2:0];
                    `DAFU_BUS_OPND:    s_d.opnd    = AVS_WRITEDATA[15:0];
                    `DAFU_BUS_WDATA:   s_d.wdata   = AVS_WRITEDATA[16:0];
                    `DAFU_BUS_STATUS: begin
                        s_d.test_flag_one = AVS_WRITEDATA[0];
                        s_d.test_flag_two = AVS_WRITEDATA[1];
                        s_d.stat_tag      = AVS_WRITEDATA[2];
                    end
                    `DAFU_BUS_GO: begin
                        s_d.busy = 1'b1;
                        s_d.st   = DAFU_ST_EXEC;
                    end
                    default: s_d.busy = s_q.busy;
                endcase
            end
        end
    end

    // the block's state register; the reset flops and the memory keep their own
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            s_q           <= '0;
            s_q.st        <= DAFU_ST_IDLE;
            s_q.bus_rdata <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    // hold the master until the answer flop is set
    assign AVS_WAITREQUEST = bus_hit & ~s_q.bus_ack;
    assign AVS_READDATA    = s_q.bus_rdata;
endmodule : dafu_core

// >>> dafu_consts.svh
// constants for the data address and flag unit
`ifndef DAFU_CONSTS_SVH
`define DAFU_CONSTS_SVH
`define DAFU_RAM_WORDS     640
`define DAFU_WORD_W        16
`define DAFU_ADDR_W        16
`define DAFU_WADDR_W       10
`define DAFU_TAG_BIT       16
`define DAFU_FLG_REL_BIT   0
`define DAFU_FLG_OFS_LO    1
`define DAFU_FLG_OFS_HI    6
`define DAFU_REG_INDEX     3'h5
`define DAFU_REG_PAGE      3'h6
`define DAFU_OP_W          4
`define DAFU_OP_IDLE       4'h0
`define DAFU_OP_LOAD_ACC   4'h1
`define DAFU_OP_STORE_ACC  4'h2
`define DAFU_OP_SET_TAGB   4'h3
`define DAFU_OP_CLR_TAGB   4'h4
`define DAFU_OP_SET_TAGW   4'h5
`define DAFU_OP_CLR_TAGW   4'h6
`define DAFU_OP_FLG_LOAD   4'h7
`define DAFU_OP_FLG_STORE  4'h8
`define DAFU_OP_FLG_AND    4'h9
`define DAFU_OP_FLG_OR     4'hA
`define DAFU_OP_FLG_XOR    4'hB
`define DAFU_OP_REG_WR     4'hC
`define DAFU_MODE_DIRECT   3'h0
`define DAFU_MODE_INDIRECT 3'h1
`define DAFU_MODE_INDEX    3'h2
`define DAFU_MODE_SHORT    3'h3
`define DAFU_MODE_LONG     3'h4
`define DAFU_BUS_CMD       4'h0
`define DAFU_BUS_REG_SEL   4'h1
`define DAFU_BUS_OPND      4'h2
`define DAFU_BUS_WDATA     4'h3
`define DAFU_BUS_RDATA     4'h4
`define DAFU_BUS_STATUS    4'h5
`define DAFU_BUS_ADDR      4'h6
`define DAFU_BUS_GO        4'h7
`define DAFU_RST_WORD      16'h0000
`endif

// >>> dafu_pkg.sv
// types for the data address and flag unit
package dafu_pkg;
    typedef enum logic [3:0] {
        DAFU_ST_IDLE = 4'b0001,
        DAFU_ST_EXEC = 4'b0010,
        DAFU_ST_WAIT = 4'b0100,
        DAFU_ST_DONE = 4'b1000
    } dafu_state_t;

    typedef struct packed {
        logic [3:0]  op;
        logic [2:0]  mode;
        logic [2:0]  reg_sel;
        logic        flg_sel;
        logic [6:0]  flag_field;
    } dafu_cmd_t;

    typedef struct packed {
        logic        we;
        logic        tag_only;
        logic [9:0]  waddr;
        logic [16:0] wdata;
    } dafu_ram_req_t;

    typedef struct packed {
        logic        rd_waitreq;
        logic [15:0] ram_addr;
    } dafu_bus_sig_t;
endpackage : dafu_pkg

// >>> dafu_tag_ram.sv
// tagged data memory: 17-bit words with tag-only write path
`timescale 1ns/1ps
`include "dafu_consts.svh"
module dafu_tag_ram
    import dafu_pkg::*;
#(
    parameter int WORDS = `DAFU_RAM_WORDS
) (
    input  wire logic          clk,
    input  wire dafu_ram_req_t req,
    input  wire logic          req_vld,
    output logic [16:0]        rdata
);
    // memory array, tag in bit 16
    logic [16:0] mem [0:WORDS-1];

    // the ten-bit word address cannot serve more than 1024 words
    if (WORDS < 1 || WORDS > 1024) begin : g_bad_words
        $error("dafu_tag_ram: WORDS out of range");
    end

    // write: tag-only writes keep the 16 data bits untouched
    always_ff @(posedge clk) begin
        if (req_vld && req.we && (32'(req.waddr) < WORDS)) begin
            if (req.tag_only) begin
                mem[req.waddr][`DAFU_TAG_BIT] <= req.wdata[`DAFU_TAG_BIT];
            end else begin
                mem[req.waddr] <= req.wdata;
            end
        end
    end

    // registered read, out-of-range reads give zero
    always_ff @(posedge clk) begin
        if (32'(req.waddr) < WORDS) begin
            rdata <= mem[req.waddr];
        end else begin
            rdata <= 17'h00000;
        end
    end
endmodule : dafu_tag_ram

// >>> dafu_core_assertions.sv
// bus-level assertions for the data address and flag unit
`timescale 1ns/1ps
module dafu_core_chk (
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    input wire logic [3:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    wire logic req = AVS_READ || AVS_WRITE;
    // request held through its single wait cycle
    sequence s_held_wait;
        req && AVS_WAITREQUEST ##1 req;
    endsequence
    // read answered at a given register index
    sequence s_rd(a);
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == a;
    endsequence
    a_idle_no_wait: assert property (!req |-> !AVS_WAITREQUEST)
        else $error("waitrequest high while idle");
    a_first_wait: assert property ($rose(req) |-> AVS_WAITREQUEST)
        else $error("no wait cycle on new request");
    a_one_wait: assert property (s_held_wait |-> !AVS_WAITREQUEST)
        else $error("more than one wait cycle");
    a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[3]
        |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
    a_status_width: assert property (s_rd(4'h5) |-> AVS_READDATA[31:4] == 28'h0)
        else $error("status upper bits set");
    a_word_width: assert property (s_rd(4'h4) |-> AVS_READDATA[31:17] == 15'h0)
        else $error("memory word wider than 17 bits");
    a_addr_width: assert property (s_rd(4'h6) |-> AVS_READDATA[31:16] == 16'h0)
        else $error("address wider than 16 bits");
    a_rdata_stands: assert property (!req ##1 !req |-> $stable(AVS_READDATA))
        else $error("read data moved while idle");
endmodule : dafu_core_chk

// >>> dafu_avs_host.sv
// bus master model standing in for the software side
`timescale 1ns/1ps
module dafu_avs_host (
    input  wire logic        clk,
    input  wire logic        waitreq,
    input  wire logic [31:0] rdata,
    output logic [3:0]       addr,
    output logic             rd,
    output logic             wr,
    output logic [31:0]      wdata,
    output logic [3:0]       be
);
    // idle bus at time zero
    initial begin
        addr = 4'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'hF;
    end
    // one transfer: request held until waitrequest is sampled low at a rising
    // edge; read data taken at that edge, release right after it
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        @(posedge clk);
        rd    <= !w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 64);
        ok = (waitreq === 1'b0);
        q  = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : xfer
endmodule : dafu_avs_host

// >>> data_address_and_flag_unit_tb_top.sv
// testbench for the data address and flag unit
`timescale 1ns/1ps
`include "dafu_consts.svh"
module data_address_and_flag_unit_tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    int          err_count = 0;
    int          checks = 0;
    int          polls = 0;
    logic [31:0] q;
    logic [2:0]  md [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    logic [15:0] ofs [5] = '{16'h0100, 16'h0, 16'h0, 16'h0010, 16'h0100};
    logic [15:0] tgt [5] = '{16'h0100, 16'h0200, 16'h0202, 16'h03F4, 16'h0300};
    logic [3:0]  fop [4] = '{`DAFU_OP_FLG_OR, `DAFU_OP_FLG_AND, `DAFU_OP_FLG_XOR,
                             `DAFU_OP_FLG_LOAD};
    logic [6:0]  ffd [4] = '{7'h02, 7'h00, 7'h02, 7'h00};
    logic        fex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    int          cyc [5] = '{32'h2, 32'h1, 32'h1, 32'h1, 32'h2};
    always #4 clk = ~clk;
    dafu_core u_dut (.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq));
    dafu_avs_host u_host (.clk(clk), .waitreq(waitreq), .rdata(rdata), .addr(addr),
        .rd(rd), .wr(wr), .wdata(wdata), .be(be));
    task automatic close_out;
        $display("err_count=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        logic ok;
        u_host.xfer(w, a, d, q, ok);
        if (!ok) begin
            err_count++;
            $display("[FAIL] waitrequest exp 0 got 1");
            close_out();
        end
    endtask : bus
    // command, operand, start, then poll busy with a bound
    task automatic run(input logic [3:0] op, input logic [2:0] m, input logic [2:0] rs,
                       input logic fs, input logic [6:0] ff, input logic [15:0] od);
        int n;
        bus(1'b1, `DAFU_BUS_CMD, {14'h0, op, m, rs, fs, ff});
        bus(1'b1, `DAFU_BUS_OPND, {16'h0, od});
        bus(1'b1, `DAFU_BUS_GO, 32'h1);
        n = 0;
        do begin
            bus(1'b0, `DAFU_BUS_STATUS, 32'h0);
            n++;
        end while (q[3] !== 1'b0 && n < 20);
        polls = n;
        if (q[3] !== 1'b0) begin
            err_count++;
            $display("[FAIL] busy exp 0 got %b", q[3]);
            close_out();
        end
    endtask : run
    task automatic setr(input logic [2:0] r, input logic [15:0] v);
        bus(1'b1, `DAFU_BUS_REG_SEL, {29'h0, r});
        bus(1'b1, `DAFU_BUS_WDATA, {16'h0, v});
        run(`DAFU_OP_REG_WR, 3'h0, r, 1'b0, 7'h0, 16'h0);
    endtask : setr
    task automatic eff(input logic [15:0] e);
        bus(1'b0, `DAFU_BUS_ADDR, 32'h0);
        chk("eaddr", {16'h0, e}, q);
    endtask : eff
    task automatic memw(input logic [15:0] a, input logic [16:0] d);
        bus(1'b1, `DAFU_BUS_WDATA, {15'h0, d});
        run(`DAFU_OP_STORE_ACC, `DAFU_MODE_DIRECT, 3'h0, 1'b0, 7'h0, a);
    endtask : memw
    // load word, compare data and the tag copied into status
    task automatic meml(input logic [15:0] a, input logic [16:0] e);
        run(`DAFU_OP_LOAD_ACC, `DAFU_MODE_DIRECT, 3'h0, 1'b0, 7'h0, a);
        bus(1'b0, `DAFU_BUS_RDATA, 32'h0);
        chk("word", {15'h0, e}, q);
        bus(1'b0, `DAFU_BUS_STATUS, 32'h0);
        chk("stat_tag", {31'h0, e[16]}, {31'h0, q[2]});
    endtask : meml
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        setr(3'h3, 16'h01F0);
        setr(`DAFU_REG_INDEX, 16'h0002);
        bus(1'b1, `DAFU_BUS_WDATA, 32'h0ABCD);
        run(`DAFU_OP_STORE_ACC, `DAFU_MODE_INDEX, 3'h3, 1'b0, 7'h0, 16'h0);
        eff(16'h01F2);
        run(`DAFU_OP_LOAD_ACC, `DAFU_MODE_INDEX, 3'h3, 1'b0, 7'h0, 16'h0);
        eff(16'h01F2);
        meml(16'h01F2, 17'h0ABCD);
        setr(`DAFU_REG_PAGE, 16'h03E4);
        run(`DAFU_OP_LOAD_ACC, `DAFU_MODE_SHORT, 3'h0, 1'b0, 7'h0, 16'h00FF);
        eff(16'h0463);
        setr(3'h1, 16'h0200);
        run(`DAFU_OP_LOAD_ACC, `DAFU_MODE_LONG, 3'h1, 1'b0, 7'h0, 16'h0254);
        eff(16'h0454);
        setr(3'h3, 16'hFFF0);
        run(`DAFU_OP_LOAD_ACC, `DAFU_MODE_LONG, 3'h3, 1'b0, 7'h0, 16'h0020);
        eff(16'h0010);
        memw(16'h0002, 17'h01234);
        run(`DAFU_OP_SET_TAGB, `DAFU_MODE_DIRECT, 3'h0, 1'b0, 7'h0, 16'h0003);
        meml(16'h0002, 17'h11234);
        run(`DAFU_OP_CLR_TAGB, `DAFU_MODE_DIRECT, 3'h0, 1'b0, 7'h0, 16'h0002);
        meml(16'h0002, 17'h01234);
        setr(3'h1, 16'h0200);
        setr(`DAFU_REG_PAGE, 16'h03E4);
        for (int i = 0; i < 5; i++) begin
            memw(tgt[i], 17'h00055);
            run(`DAFU_OP_SET_TAGB, md[i], 3'h1, 1'b0, 7'h0, ofs[i]);
            chk("tagb_polls", cyc[i], polls);
            meml(tgt[i], 17'h10055);
        end
        memw(16'h0000, 17'h0);
        memw(16'h0002, 17'h0);
        run(`DAFU_OP_SET_TAGW, 3'h0, 3'h0, 1'b0, 7'h02, 16'h0);
        chk("tagw_polls", 32'h1, polls);
        meml(16'h0002, 17'h10000);
        meml(16'h0000, 17'h00000);
        memw(16'h0204, 17'h05A5A);
        setr(`DAFU_REG_PAGE, 16'h0100);
        bus(1'b1, `DAFU_BUS_STATUS, 32'h2);
        run(`DAFU_OP_FLG_STORE, 3'h0, 3'h0, 1'b1, 7'h05, 16'h0);
        meml(16'h0204, 17'h15A5A);
        bus(1'b1, `DAFU_BUS_STATUS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            run(fop[i], 3'h0, 3'h0, 1'b0, ffd[i], 16'h0);
            bus(1'b0, `DAFU_BUS_STATUS, 32'h0);
            chk("tf1", {31'h0, fex[i]}, {31'h0, q[0]});
        end
        memw(16'h04FE, 17'h1BEEF);
        meml(16'h04FE, 17'h1BEEF);
        meml(16'h0500, 17'h00000);
        memw(16'h0010, 17'h00077);
        memw(16'h0810, 17'h1FFFF);
        meml(16'h0010, 17'h00077);
        meml(16'h0810, 17'h00000);
        bus(1'b0, 4'hF, 32'h0);
        chk("unmapped", 32'h0, q);
        close_out();
    end
endmodule : data_address_and_flag_unit_tb_top
bind dafu_core dafu_core_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
